// ===== design/odf_pkg.sv
package odf_pkg;

    // Serial programming word layout
    localparam int          ODF_WORD_BITS   = 16;
    localparam int          ODF_HEAD_BITS   = 8;
    localparam logic [4:0]  ODF_CNT_LAST    = 5'h0F;
    localparam logic [4:0]  ODF_CNT_HEAD    = 5'h07;
    localparam logic [4:0]  ODF_CNT_DONE    = 5'h10;

    // Register offsets (seven-bit address)
    localparam logic [6:0]  ODF_ADDR_RESET  = 7'h00;
    localparam logic [6:0]  ODF_ADDR_FORMAT = 7'h04;

    // Reset register field
    localparam int          ODF_RESET_BIT   = 7;

    // Format register fields
    localparam int          ODF_TP_HI       = 5;
    localparam int          ODF_TP_LO       = 3;
    localparam int          ODF_ABP_BIT     = 2;
    localparam int          ODF_OUTPUT_SCRAMBLER_ENABLE_BIT    = 1;
    localparam int          ODF_TWOS_BIT    = 0;
    localparam logic [7:0]  ODF_FORMAT_MASK = 8'h3F;
    localparam logic [7:0]  ODF_FORMAT_RST  = 8'h00;

    // Test pattern selector codes
    localparam logic [2:0]  ODF_TP_OFF      = 3'h0;
    localparam logic [2:0]  ODF_TP_ZERO     = 3'h1;
    localparam logic [2:0]  ODF_TP_ONE      = 3'h3;
    localparam logic [2:0]  ODF_TP_CHECK    = 3'h5;
    localparam logic [2:0]  ODF_TP_ALT      = 3'h7;

    // Pattern words, overrange flag in bit 16
    localparam logic [16:0] ODF_PAT_ZERO    = 17'h00000;
    localparam logic [16:0] ODF_PAT_ONE     = 17'h1FFFF;
    localparam logic [16:0] ODF_PAT_CHK_A   = 17'h15555;
    localparam logic [16:0] ODF_PAT_CHK_B   = 17'h0AAAA;
    localparam logic [15:0] ODF_ODD_MASK    = 16'hAAAA;

endpackage : odf_pkg

// ===== design/odf_formatter.sv
`timescale 1ns/10ps

module odf_formatter
    import odf_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             nrst,
    // Settings
    input  wire logic [7:0]       format_cfg,
    // Pattern override from the selector
    input  wire logic             pat_on,
    input  wire logic [16:0]      pat_word,
    // Raw conversion result, offset binary
    input  wire logic             sample_valid,
    input  wire logic [WIDTH-1:0] sample_word_bits,
    input  wire logic             overrange_flag,
    // Formatted output word
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_word_bits,
    output logic                  out_overrange_flag
);

    logic             alternate_polarity_enable;
    logic             output_scrambler_enable;
    logic             signed_coding_select;
    logic [WIDTH-1:0] data_next;

    assign alternate_polarity_enable = format_cfg[ODF_ABP_BIT];
    assign output_scrambler_enable   = format_cfg[ODF_OUTPUT_SCRAMBLER_ENABLE_BIT];
    assign signed_coding_select      = format_cfg[ODF_TWOS_BIT];

    always_comb begin
        data_next = sample_word_bits;
        if (signed_coding_select && !alternate_polarity_enable) begin
            data_next[WIDTH-1] = ~data_next[WIDTH-1];
        end
        if (alternate_polarity_enable) begin
            data_next = data_next ^ ODF_ODD_MASK[WIDTH-1:0];
        end
        if (output_scrambler_enable && data_next[0]) begin
            data_next[WIDTH-1:1] = ~data_next[WIDTH-1:1];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            out_valid          <= 1'b0;
            out_word_bits      <= '0;
            out_overrange_flag <= 1'b0;
        end else begin
            out_valid <= sample_valid;
            if (sample_valid && pat_on) begin
                out_word_bits      <= pat_word[WIDTH-1:0];
                out_overrange_flag <= pat_word[16];
            end else if (sample_valid) begin
                out_word_bits      <= data_next;
                out_overrange_flag <= overrange_flag;
            end
        end
    end

endmodule : odf_formatter

// ===== design/odf_top.sv
`timescale 1ns/10ps

// Function
// - Bits 5..3 select test pattern; 000 passes normal results.
// - Selector 001 drives flag and all data bits low.
// - Selector 011 drives flag and all data bits high.
// - Selector 101 alternates 1_5555 and 0_AAAA on successive words.
// - Selector 111 alternates all zeros and all ones per word.
// - Bit 2 enables alternate polarity, which forces offset binary.
// - Bit 1 enables the output scrambler; off passes data.
// - Bit 0 picks offset binary (0) or two's complement (1).
// - Bits 7 and 6 of the format register are ignored.
// - Serial word: read flag, seven address bits, eight data bits.
// - Software reset clears mode registers to zero.
module odf_top
    import odf_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             nrst,
    // Serial programming port
    input  wire logic             programming_port_select,
    input  wire logic             cs_n,
    input  wire logic             sck,
    input  wire logic             sdi,
    output logic                  sdo_out,
    output logic                  sdo_oe,
    // Conversion results
    input  wire logic             sample_valid,
    input  wire logic [WIDTH-1:0] sample_word_bits,
    input  wire logic             overrange_flag,
    // Formatted output
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_word_bits,
    output logic                  out_overrange_flag
);

    logic        sck_reg;
    logic        sck_rise;
    logic        sck_fall;
    logic        port_on;
    logic [4:0]  bit_cnt_reg;
    logic [15:0] shift_reg;
    logic        reading_reg;
    logic [7:0]  rd_shift_reg;
    logic        wr_pulse_reg;
    logic [6:0]  wr_addr_reg;
    logic [7:0]  wr_data_reg;
    logic        soft_rst_reg;
    logic [7:0]  format_reg;
    logic [7:0]  format_next;
    logic [2:0]  test_pattern_select;
    logic        phase_reg;
    logic        pat_on;
    logic [16:0] pat_word;

    function automatic logic [7:0] read_mux(input logic [6:0] addr,
                                            input logic [7:0] fmt);
        read_mux = 8'h00;
        if (addr == ODF_ADDR_FORMAT) begin
            read_mux = fmt;
        end
    endfunction : read_mux

    // Write strobe decode, shared by both register targets
    function automatic logic wr_hit(input logic       pulse,
                                    input logic [6:0] addr,
                                    input logic [6:0] target);
        wr_hit = pulse && addr == target;
    endfunction : wr_hit

    // Serial port only serves when strapped for serial mode
    assign port_on  = !programming_port_select && !cs_n;
    assign sck_rise = sck && !sck_reg;
    assign sck_fall = !sck && sck_reg;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sck_reg <= 1'b0;
        end else begin
            sck_reg <= sck;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_reg <= 5'h00;
            shift_reg   <= 16'h0000;
        end else if (!port_on) begin
            bit_cnt_reg <= 5'h00;
        end else if (sck_rise && bit_cnt_reg != ODF_CNT_DONE) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            shift_reg   <= {shift_reg[14:0], sdi};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_pulse_reg <= 1'b0;
            wr_addr_reg  <= 7'h00;
            wr_data_reg  <= 8'h00;
        end else begin
            wr_pulse_reg <= 1'b0;
            if (port_on && sck_rise && bit_cnt_reg == ODF_CNT_LAST
                && !shift_reg[14]) begin
                wr_pulse_reg <= 1'b1;
                wr_addr_reg  <= shift_reg[13:7];
                wr_data_reg  <= {shift_reg[6:0], sdi};
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reading_reg  <= 1'b0;
            rd_shift_reg <= 8'h00;
        end else if (!port_on) begin
            reading_reg  <= 1'b0;
        end else if (sck_rise && bit_cnt_reg == ODF_CNT_HEAD) begin
            reading_reg  <= shift_reg[6];
            rd_shift_reg <= read_mux({shift_reg[5:0], sdi}, format_reg);
        end else if (sck_fall && reading_reg
                     && bit_cnt_reg != ODF_CNT_DONE) begin
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
        end
    end

    // Open drain: only ever pulls low, released between frames
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sdo_out <= 1'b0;
            sdo_oe  <= 1'b0;
        end else if (!port_on) begin
            sdo_out <= 1'b0;
            sdo_oe  <= 1'b0;
        end else if (sck_fall && reading_reg
                     && bit_cnt_reg != ODF_CNT_DONE) begin
            sdo_out <= 1'b0;
            sdo_oe  <= !rd_shift_reg[7];
        end else if (sck_fall) begin
            sdo_oe  <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= wr_hit(wr_pulse_reg, wr_addr_reg, ODF_ADDR_RESET)
                            && wr_data_reg[ODF_RESET_BIT];
        end
    end

    always_comb begin
        format_next = format_reg;
        if (soft_rst_reg) begin
            format_next = ODF_FORMAT_RST;
        end else if (wr_hit(wr_pulse_reg, wr_addr_reg, ODF_ADDR_FORMAT)) begin
            format_next = wr_data_reg & ODF_FORMAT_MASK;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            format_reg <= ODF_FORMAT_RST;
        end else begin
            format_reg <= format_next;
        end
    end

    assign test_pattern_select = format_reg[ODF_TP_HI:ODF_TP_LO];

    always_comb begin
        pat_on   = 1'b1;
        pat_word = ODF_PAT_ZERO;
        unique case (test_pattern_select)
            ODF_TP_OFF:   pat_on   = 1'b0;
            ODF_TP_ZERO:  pat_word = ODF_PAT_ZERO;
            ODF_TP_ONE:   pat_word = ODF_PAT_ONE;
            ODF_TP_CHECK: pat_word = phase_reg ? ODF_PAT_CHK_B
                                               : ODF_PAT_CHK_A;
            ODF_TP_ALT:   pat_word = phase_reg ? ODF_PAT_ONE
                                               : ODF_PAT_ZERO;
            // Reserved codes pass normal data
            default:      pat_on   = 1'b0;
        endcase
    end

    // Phase restarts when patterns are off so each pattern run
    // starts on its first word
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= 1'b0;
        end else if (!pat_on) begin
            phase_reg <= 1'b0;
        end else if (sample_valid) begin
            phase_reg <= ~phase_reg;
        end
    end

    // Output path; reserved selector codes fall back to normal data
    odf_formatter #(
        .WIDTH              (WIDTH)
    ) u_formatter (
        .mclk               (mclk),
        .nrst               (nrst),
        .format_cfg         (format_reg),
        .pat_on             (pat_on),
        .pat_word           (pat_word),
        .sample_valid       (sample_valid),
        .sample_word_bits   (sample_word_bits),
        .overrange_flag     (overrange_flag),
        .out_valid          (out_valid),
        .out_word_bits      (out_word_bits),
        .out_overrange_flag (out_overrange_flag)
    );

endmodule : odf_top

// ===== bench/odf_props.sv
`timescale 1ns/10ps

module odf_props #(
    parameter int WIDTH = 16
) (
    // Watched top ports
    input wire logic             mclk,
    input wire logic             nrst,
    input wire logic             cs_n,
    input wire logic             sample_valid,
    input wire logic             out_valid,
    input wire logic [WIDTH-1:0] out_word_bits,
    input wire logic             out_overrange_flag,
    input wire logic             sdo_out,
    input wire logic             sdo_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_valid_delay: assert property (sample_valid |=> out_valid)
        else $error("out_valid missing after sample");
    a_valid_pulse: assert property (!sample_valid |=> !out_valid)
        else $error("out_valid without sample");
    a_word_hold: assert property (
        !sample_valid |=> $stable(out_word_bits))
        else $error("output word moved between samples");
    a_flag_change: assert property (
        $changed(out_overrange_flag) |-> out_valid)
        else $error("flag moved without a word");
    a_word_change: assert property (
        $changed(out_word_bits) |-> out_valid)
        else $error("word moved without out_valid");
    // Initial edge skipped: async clear may not have fired yet at time zero
    a_reset_clear: assert property (disable iff (1'b0)
        !nrst && !$past(nrst) |-> !out_valid && out_word_bits == '0)
        else $error("outputs not clear in reset");
    a_sdo_release: assert property (cs_n |=> !sdo_oe)
        else $error("sdo driven after deselect");
    a_sdo_drain: assert property (sdo_out == 1'b0)
        else $error("open drain output drove high");

    c_sample: cover property (sample_valid);
    c_read: cover property ($rose(sdo_oe));
    c_flag: cover property (out_valid && out_overrange_flag);
endmodule : odf_props

bind odf_top odf_props #(.WIDTH(WIDTH)) u_props (
    .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sample_valid(sample_valid),
    .out_valid(out_valid), .out_word_bits(out_word_bits),
    .out_overrange_flag(out_overrange_flag), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe)
);

// ===== bench/odf_rx_model.sv
`timescale 1ns/10ps

module odf_rx_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Formatted words
    input  wire logic        out_valid,
    input  wire logic [15:0] out_word_bits,
    // Recovered sample and word count
    output logic      [15:0] rx_data,
    output logic      [15:0] rx_count
);
    assign rx_data = out_word_bits[0] ? out_word_bits ^ 16'hFFFE
                                      : out_word_bits;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            rx_count <= 16'h0000;
        else if (out_valid)
            rx_count <= rx_count + 16'h0001;
    end
endmodule : odf_rx_model

// ===== bench/odf_top_tb.sv
`timescale 1ns/10ps

module odf_top_tb;
    import odf_pkg::*;
    logic        mclk = 1'b0, nrst = 1'b1, cs_n = 1'b1, sck = 1'b0;
    logic        pps = 1'b0;
    logic [15:0] rx_cnt;
    logic        sdi = 1'b0, sample_valid = 1'b0, overrange_flag = 1'b0;
    logic [15:0] sample_word_bits = 16'h0000, rx_data, out_word_bits;
    logic        out_valid, out_overrange_flag, sdo_out, sdo_oe, phase;
    logic [16:0] d, got;
    logic [7:0]  cfg, rd;
    logic [2:0]  tps [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
    int          seed = 49889, miscompares = 0, compares = 0;

    always #5 mclk = ~mclk;
    assign got = {out_overrange_flag, out_word_bits};

    odf_top #(.WIDTH(16)) u_dut (
        .mclk(mclk), .nrst(nrst), .programming_port_select(pps),
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .sample_valid(sample_valid),
        .sample_word_bits(sample_word_bits), .overrange_flag(overrange_flag),
        .out_valid(out_valid), .out_word_bits(out_word_bits),
        .out_overrange_flag(out_overrange_flag)
    );
    odf_rx_model u_rx (
        .mclk(mclk), .nrst(nrst), .out_valid(out_valid),
        .out_word_bits(out_word_bits), .rx_data(rx_data), .rx_count(rx_cnt)
    );

    task automatic chk(input string nm, input logic [16:0] seen,
                       input logic [16:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, want, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // Flag, address, data, MSB first; line pulled up
    task automatic spi(input logic [15:0] w);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            repeat (3) @(posedge mclk);
            #1 sck = 1'b1;
            if (i < 8)
                rd[i] = ~sdo_oe;
            repeat (3) @(posedge mclk);
            #1 sck = 1'b0;
        end
        repeat (3) @(posedge mclk);
        #1 cs_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask : spi

    function automatic logic [16:0] fexp(input logic [7:0] c,
                                         input logic [16:0] v);
        logic [15:0] x;
        x = v[15:0];
        case (c[5:3])
            ODF_TP_ZERO:  return ODF_PAT_ZERO;
            ODF_TP_ONE:   return ODF_PAT_ONE;
            ODF_TP_CHECK: return phase ? ODF_PAT_CHK_B : ODF_PAT_CHK_A;
            ODF_TP_ALT:   return phase ? ODF_PAT_ONE : ODF_PAT_ZERO;
            default: ;
        endcase
        // Sign flip suppressed by polarity mode
        if (c[0] && !c[2])
            x[15] = ~x[15];
        if (c[2])
            x = x ^ ODF_ODD_MASK;
        if (c[1] && x[0])
            x[15:1] = ~x[15:1];
        return {v[16], x};
    endfunction : fexp

    task automatic smp();
        d = 17'($random(seed));
        {overrange_flag, sample_word_bits} = d;
        sample_valid = 1'b1;
        @(posedge mclk);
        #1 sample_valid = 1'b0;
        chk("valid", {16'h0000, out_valid}, 17'h00001);
        chk("word", got, fexp(cfg, d));
        if (cfg[5:0] == 6'h02)
            chk("rx", {1'b0, rx_data}, {1'b0, d[15:0]});
        phase = ~phase;
        @(posedge mclk);
        #1;
    endtask : smp

    initial begin
        // Fall after time zero so the asynchronous clear sees an edge
        #1 nrst = 1'b0;
        repeat (4) @(posedge mclk);
        #1 nrst = 1'b1;
        spi({1'b1, ODF_ADDR_FORMAT, 8'h00});
        chk("fmt_rst", {9'h000, rd}, 17'h00000);
        for (int k = 0; k < 24; k++) begin
            cfg = 8'($random(seed));
            cfg[5:3] = (k < 8) ? 3'h0 : tps[k % 5];
            if (k < 8)
                cfg[2:0] = 3'(k);
            // Selector off first so pattern phase restarts
            spi({1'b0, ODF_ADDR_FORMAT, 8'h00});
            spi({1'b0, ODF_ADDR_FORMAT, cfg});
            phase = 1'b0;
            spi({1'b1, ODF_ADDR_FORMAT, 8'h00});
            chk("fmt_rd", {9'h000, rd},
                {9'h000, cfg & ODF_FORMAT_MASK});
            repeat (5) smp();
        end
        spi({1'b0, ODF_ADDR_RESET, 8'h80});
        spi({1'b1, ODF_ADDR_FORMAT, 8'h00});
        chk("soft_rst", {9'h000, rd}, 17'h00000);
        cfg = 8'h00;
        phase = 1'b0;
        smp();
        // Strapped for parallel: serial writes must not land
        pps = 1'b1;
        spi({1'b0, ODF_ADDR_FORMAT, 8'h3F});
        pps = 1'b0;
        spi({1'b1, ODF_ADDR_FORMAT, 8'h00});
        chk("strap", {9'h000, rd}, 17'h00000);
        spi({1'b1, 7'h05, 8'h00});
        chk("unmapped", {9'h000, rd}, 17'h00000);
        // Every sample word reached the receiver exactly once
        chk("rx_count", {1'b0, rx_cnt}, 17'h00079);
        give_verdict();
    end

    // Run needs about 8200 cycles
    initial begin
        #300000;
        miscompares++;
        give_verdict();
    end
endmodule : odf_top_tb
